// ===== verilog/axis_defines.svh
`ifndef AXIS_DEFINES_SVH
`define AXIS_DEFINES_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_STATUS 8'h08
`define OFS_TARGET 8'h0C
`define OFS_ACTUAL 8'h10
`define OFS_DISPLAY 8'h14
`define OFS_PIN 8'h18
`define OFS_PROG_ADDR 8'h1C
`define OFS_PROG_DATA 8'h20
`define OFS_PROG_LEN 8'h24
`define OFS_SET_IDX 8'h28
`define PAR_PAGE 2'b01
// ----------------------------------------
// parameter slots at 0x40 + 4*index
// ----------------------------------------
`define PI_SLOW_F 4'h0
`define PI_SLOW_B 4'h1
`define PI_CREEP_F 4'h2
`define PI_CREEP_B 4'h3
`define PI_CORR_F 4'h4
`define PI_CORR_B 4'h5
`define PI_TOL 4'h6
`define PI_MANIP 4'h7
`define PI_COMP 4'h8
`define PI_LOOP 4'h9
`define PI_REF 4'hA
`define PI_RETR 4'hB
`define PI_END_MIN 4'hC
`define PI_END_MAX 4'hD
`define PI_FACTOR 4'hE
`define PI_DWELL 4'hF
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_MODE_LO 0
`define CTRL_JOG_F 2
`define CTRL_JOG_B 3
`define CTRL_PID 4
`define CTRL_RETR_TO 5
`define CTRL_APPR_F 6
`define CMD_START 0
`define CMD_STOP 1
`define CMD_REF 2
`define CMD_LEAVE 3
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RST_END_MIN 32'h8000_0000
`define RST_END_MAX 32'h7FFF_FFFF
`define RST_FACTOR 32'h0000_0001
`define PIN_CODE 32'h0003_D2C5
`define DWELL_MAX 32'h0000_03E7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 125
`define ESC_HOLD_MS 3000
`define TICK_MS 100
`define ESC_HOLD_CYC (`ESC_HOLD_MS * 1000 * `CLK_MHZ)
`define TICK_CYC (`TICK_MS * 1000 * `CLK_MHZ)
`define PROG_DEPTH 1000
`endif

// ===== verilog/axis_pkg.sv
package axis_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_MOVE = 5'h04,
    ST_DWELL = 5'h08,
    ST_JOG = 5'h10
  } motion_t;
  typedef enum logic [1:0] {
    MODE_MANUAL = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_PROGRAM = 2'h2
  } mode_t;
endpackage

// ===== verilog/axis_if.sv
`timescale 1ns/100ps
interface enc_if;
  logic step;
  logic up;
  modport src (output step, output up);
  modport dst (input step, input up);
endinterface

interface prog_if;
  logic wr_en;
  logic [9:0] wr_addr;
  logic [31:0] wr_data;
  logic [9:0] rd_addr;
  logic [31:0] rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface

// ===== verilog/quad_decode.sv
`timescale 1ns/100ps
module quad_decode (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // encoder tracks
  input wire logic enc_a,
  input wire logic enc_b,
  // counting edges
  enc_if.src enc
);
  logic [2:0] a_s_q;
  logic [2:0] b_s_q;
  logic a_q;
  logic b_q;
  logic a_new;
  logic b_new;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_s_q <= 3'h0;
      b_s_q <= 3'h0;
    end else begin
      a_s_q <= {a_s_q[1:0], enc_a};
      b_s_q <= {b_s_q[1:0], enc_b};
    end
  end

  // a level is accepted only once stages two and three agree
  always_comb begin
    a_new = (a_s_q[1] == a_s_q[2]) ? a_s_q[2] : a_q;
    b_new = (b_s_q[1] == b_s_q[2]) ? b_s_q[2] : b_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      enc.step <= 1'b0;
      enc.up <= 1'b0;
    end else begin
      a_q <= a_new;
      b_q <= b_new;
      // every edge of either track counts; a double jump is dropped
      enc.step <= (a_new ^ a_q) ^ (b_new ^ b_q);
      enc.up <= a_q ^ b_new;
    end
  end
endmodule

// ===== verilog/prog_mem.sv
`timescale 1ns/100ps
module prog_mem #(
  parameter int DEPTH = 1000
) (
  // clock
  input wire logic mclk,
  // access
  prog_if.mem p
);
  logic [31:0] mem [0:DEPTH-1];

  generate
    if (DEPTH < 1 || DEPTH > 1024) begin : g_bad
      $error("prog_mem depth out of range");
    end
  endgenerate

  // no reset: contents are software's to load
  always_ff @(posedge mclk) begin
    if (p.wr_en && p.wr_addr < 10'(DEPTH)) begin
      mem[p.wr_addr] <= p.wr_data;
    end
  end

  assign p.rd_data = (p.rd_addr < 10'(DEPTH)) ? mem[p.rd_addr] : 32'h0000_0000;
endmodule

// ===== verilog/axis_position.sv
`timescale 1ns/100ps
`include "axis_defines.svh"
module axis_position import axis_pkg::*; #(
  parameter int unsigned ESC_HOLD_CYC = `ESC_HOLD_CYC,
  parameter int unsigned TICK_CYC = `TICK_CYC,
  parameter int PROG_DEPTH = `PROG_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // field pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic retract_in,
  input wire logic escape_key,
  // drive outputs
  output logic drive_fast,
  output logic drive_slow,
  output logic drive_creep,
  output logic dir_fwd,
  output logic dir_bwd,
  output logic tol_zone,
  output logic in_position
);
  generate
    if (ESC_HOLD_CYC < 1 || TICK_CYC < 1) begin : g_bad
      $error("axis_position timing counts must be at least one");
    end
  endgenerate

  enc_if enc ();
  prog_if pm ();

  quad_decode u_quad (.mclk(mclk), .rst(rst), .enc_a(enc_a), .enc_b(enc_b), .enc(enc));
  prog_mem #(.DEPTH(PROG_DEPTH)) u_mem (.mclk(mclk), .p(pm));

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, wr_par, rd_hit, wr_hit;
  logic [31:0] wmask, rd_val;
  logic [7:0] wa;

  assign wa = awaddr_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_par = wa[7:6] == `PAR_PAGE;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_hit = wr_par || wa <= `OFS_PROG_LEN;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && wready_q) begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] par_q [0:15];
  logic [31:0] ctrl_q, target_q, prog_len_q;
  logic [9:0] prog_addr_q, idx_q;
  logic unlocked_q, service_q;
  logic cmd_start, cmd_stop, cmd_ref, cmd_leave;
  motion_t st_q;
  mode_t mode;
  logic signed [31:0] act_q, disp_q, goal_q, tgt_q;
  logic fast_q, slow_q, creep_q, fwd_q, bwd_q, tol_q, inpos_q;

  assign mode = mode_t'(ctrl_q[`CTRL_MODE_LO +: 2]);
  assign cmd_start = wr_fire && wa == `OFS_CMD && wmask[`CMD_START] && wdata_q[`CMD_START];
  assign cmd_stop = wr_fire && wa == `OFS_CMD && wmask[`CMD_STOP] && wdata_q[`CMD_STOP];
  assign cmd_ref = wr_fire && wa == `OFS_CMD && wmask[`CMD_REF] && wdata_q[`CMD_REF];
  assign cmd_leave = wr_fire && wa == `OFS_CMD && wmask[`CMD_LEAVE] && wdata_q[`CMD_LEAVE];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        par_q[i] <= 32'h0000_0000;
      end
      par_q[`PI_END_MIN] <= `RST_END_MIN;
      par_q[`PI_END_MAX] <= `RST_END_MAX;
      par_q[`PI_FACTOR] <= `RST_FACTOR;
    end else if (wr_fire && wr_par && unlocked_q) begin
      par_q[wa[5:2]] <= (par_q[wa[5:2]] & ~wmask) | (wdata_q & wmask);
    end
  end

  // target, mode and program entries stay free without the PIN
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 32'h0000_0000;
      target_q <= 32'h0000_0000;
      prog_len_q <= 32'h0000_0000;
      prog_addr_q <= 10'h000;
    end else if (wr_fire) begin
      case (wa)
        `OFS_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
        `OFS_TARGET: target_q <= (target_q & ~wmask) | (wdata_q & wmask);
        `OFS_PROG_LEN: prog_len_q <= (prog_len_q & ~wmask) | (wdata_q & wmask);
        `OFS_PROG_ADDR: prog_addr_q <= wdata_q[9:0];
        `OFS_PROG_DATA: prog_addr_q <= prog_addr_q + 10'h001;
        default: ;
      endcase
    end
  end

  assign pm.wr_en = wr_fire && wa == `OFS_PROG_DATA;
  assign pm.wr_addr = prog_addr_q;
  assign pm.wr_data = wdata_q;
  assign pm.rd_addr = idx_q;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (s_axi_araddr[7:6] == `PAR_PAGE) begin
      rd_val = par_q[s_axi_araddr[5:2]];
    end else begin
      case ({s_axi_araddr[7:2], 2'h0})
        `OFS_CTRL: rd_val = ctrl_q;
        `OFS_CMD: rd_val = 32'h0000_0000;
        `OFS_STATUS: rd_val = {18'h0, service_q, unlocked_q, inpos_q, tol_q, bwd_q, fwd_q,
                               creep_q, slow_q, fast_q, st_q};
        `OFS_TARGET: rd_val = target_q;
        `OFS_ACTUAL: rd_val = act_q;
        `OFS_DISPLAY: rd_val = disp_q;
        `OFS_PIN: rd_val = 32'h0000_0000;
        `OFS_PROG_ADDR: rd_val = {22'h0, prog_addr_q};
        `OFS_PROG_DATA: rd_val = pm.rd_data;
        `OFS_PROG_LEN: rd_val = prog_len_q;
        `OFS_SET_IDX: rd_val = {22'h0, idx_q};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // pins, service level and PIN
  // ----------------------------------------
  logic [2:0] esc_s_q, ret_s_q;
  logic esc_q, ret_q, ret_rise;
  logic [31:0] esc_cnt_q, tick_cnt_q;
  logic tick_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      esc_s_q <= 3'h0;
      ret_s_q <= 3'h0;
      esc_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      esc_s_q <= {esc_s_q[1:0], escape_key};
      ret_s_q <= {ret_s_q[1:0], retract_in};
      if (esc_s_q[1] == esc_s_q[2]) esc_q <= esc_s_q[2];
      if (ret_s_q[1] == ret_s_q[2]) ret_q <= ret_s_q[2];
    end
  end
  assign ret_rise = ret_s_q[1] == ret_s_q[2] && ret_s_q[2] && !ret_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      esc_cnt_q <= 32'h0000_0000;
      service_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else begin
      // a release restarts the hold time
      esc_cnt_q <= !esc_q ? 32'h0000_0000 : (esc_cnt_q < ESC_HOLD_CYC ? esc_cnt_q + 32'h1 : esc_cnt_q);
      if (cmd_leave) begin
        service_q <= 1'b0;
        unlocked_q <= 1'b0;
      end
      // a key still held outranks a leave in the same cycle
      if (esc_q && esc_cnt_q + 32'h1 >= ESC_HOLD_CYC) service_q <= 1'b1;
      if (wr_fire && wa == `OFS_PIN && service_q && wdata_q == `PIN_CODE) unlocked_q <= 1'b1;
    end
  end

  // tenth-second enable for the dwell count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_cnt_q + 32'h1 >= TICK_CYC;
      tick_cnt_q <= (tick_cnt_q + 32'h1 >= TICK_CYC) ? 32'h0000_0000 : tick_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------
  // position
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      act_q <= 32'sh0000_0000;
    end else if (cmd_ref) begin
      act_q <= par_q[`PI_REF];
    end else if (enc.step) begin
      act_q <= enc.up ? act_q + par_q[`PI_FACTOR] : act_q - par_q[`PI_FACTOR];
    end
  end

  // ----------------------------------------
  // motion sequencing
  // ----------------------------------------
  logic signed [31:0] new_tgt, raw_tgt, new_goal, d_start, d_goal, d_tgt;
  logic [31:0] rem, tol_win, corr, creep, slow, comp, loopw, dwell;
  logic go, go_fwd, appr_f, loop_new, phase_q, at_stop, more;
  logic [9:0] dwell_q;

  assign appr_f = ctrl_q[`CTRL_APPR_F];
  assign comp = par_q[`PI_COMP];
  assign loopw = par_q[`PI_LOOP];
  assign dwell = par_q[`PI_DWELL] > `DWELL_MAX ? `DWELL_MAX : par_q[`PI_DWELL];
  assign go = st_q == ST_LOAD || (st_q == ST_IDLE && mode == MODE_SINGLE && (cmd_start || ret_rise));
  assign more = mode == MODE_PROGRAM && 32'(idx_q) + 32'h1 < prog_len_q;

  always_comb begin
    raw_tgt = target_q;
    if (st_q == ST_LOAD) raw_tgt = pm.rd_data;
    else if (ret_rise) raw_tgt = ctrl_q[`CTRL_RETR_TO] ? par_q[`PI_RETR] : act_q + par_q[`PI_RETR];
    new_tgt = raw_tgt < $signed(par_q[`PI_END_MIN]) ? par_q[`PI_END_MIN] : raw_tgt;
    new_tgt = new_tgt > $signed(par_q[`PI_END_MAX]) ? par_q[`PI_END_MAX] : new_tgt;
    d_start = new_tgt - act_q;
    go_fwd = d_start > 0;
    new_goal = new_tgt;
    loop_new = 1'b0;
    if (comp != 32'h0 && go_fwd != appr_f && d_start != 0) begin
      new_goal = appr_f ? new_tgt - comp : new_tgt + comp;
      loop_new = 1'b1;
    end else if (loopw != 32'h0 && (d_start < 0 ? -d_start : d_start) <= $signed(loopw)) begin
      new_goal = appr_f ? new_tgt - loopw : new_tgt + loopw;
      loop_new = 1'b1;
    end
    d_goal = goal_q - act_q;
    rem = d_goal < 0 ? -d_goal : d_goal;
    d_tgt = tgt_q - act_q;
    corr = d_goal > 0 ? par_q[`PI_CORR_F] : par_q[`PI_CORR_B];
    creep = d_goal > 0 ? par_q[`PI_CREEP_F] : par_q[`PI_CREEP_B];
    slow = d_goal > 0 ? par_q[`PI_SLOW_F] : par_q[`PI_SLOW_B];
    // analogue mode: correction distance becomes the window
    tol_win = ctrl_q[`CTRL_PID] ? par_q[`PI_CORR_F] : par_q[`PI_TOL];
    at_stop = rem <= corr;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      goal_q <= 32'sh0000_0000;
      tgt_q <= 32'sh0000_0000;
      phase_q <= 1'b0;
      dwell_q <= 10'h000;
      idx_q <= 10'h000;
    end else if (cmd_stop) begin
      st_q <= ST_IDLE;
    end else if (go) begin
      st_q <= ST_MOVE;
      tgt_q <= new_tgt;
      goal_q <= new_goal;
      phase_q <= loop_new;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (mode == MODE_PROGRAM && cmd_start && prog_len_q != 32'h0) begin
            idx_q <= 10'h000;
            st_q <= ST_LOAD;
          end else if (mode == MODE_MANUAL && (ctrl_q[`CTRL_JOG_F] || ctrl_q[`CTRL_JOG_B])) begin
            st_q <= ST_JOG;
          end
        end
        ST_MOVE: begin
          if (at_stop && phase_q) begin
            dwell_q <= dwell[9:0];
            st_q <= ST_DWELL;
          end else if (at_stop) begin
            if (more) begin
              idx_q <= idx_q + 10'h001;
              st_q <= ST_LOAD;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_DWELL: begin
          if (dwell_q == 10'h000) begin
            goal_q <= tgt_q;
            phase_q <= 1'b0;
            st_q <= ST_MOVE;
          end else if (tick_q) begin
            dwell_q <= dwell_q - 10'h001;
          end
        end
        ST_JOG: if (mode != MODE_MANUAL || !(ctrl_q[`CTRL_JOG_F] || ctrl_q[`CTRL_JOG_B])) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {fast_q, slow_q, creep_q, fwd_q, bwd_q} <= 5'h00;
    end else if (st_q == ST_MOVE && !at_stop) begin
      fast_q <= rem > slow;
      slow_q <= rem <= slow && rem > creep;
      creep_q <= rem <= creep;
      fwd_q <= d_goal > 0;
      bwd_q <= d_goal < 0;
    end else if (st_q == ST_JOG) begin
      {fast_q, creep_q} <= 2'h0;
      slow_q <= 1'b1;
      fwd_q <= ctrl_q[`CTRL_JOG_F];
      bwd_q <= !ctrl_q[`CTRL_JOG_F];
    end else begin
      {fast_q, slow_q, creep_q, fwd_q, bwd_q} <= 5'h00;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tol_q <= 1'b0;
      inpos_q <= 1'b0;
      disp_q <= 32'sh0000_0000;
    end else begin
      tol_q <= (d_tgt < 0 ? -d_tgt : d_tgt) <= $signed(tol_win);
      if (go || st_q == ST_IDLE && cmd_start || st_q == ST_JOG) inpos_q <= 1'b0;
      // only the last set of a chain reports in position
      else if (st_q == ST_MOVE && at_stop && !phase_q && !more) inpos_q <= 1'b1;
      // only the shown value snaps; act_q is never touched
      disp_q <= (par_q[`PI_MANIP] != 32'h0 && (d_tgt < 0 ? -d_tgt : d_tgt) <= $signed(par_q[`PI_MANIP]))
                ? tgt_q : act_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign drive_fast = fast_q;
  assign drive_slow = slow_q;
  assign drive_creep = creep_q;
  assign dir_fwd = fwd_q;
  assign dir_bwd = bwd_q;
  assign tol_zone = tol_q;
  assign in_position = inpos_q;
endmodule

// ===== verification/axis_monitor.sv
`timescale 1ns/100ps
module axis_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // drive outputs
  input wire logic drive_fast,
  input wire logic drive_slow,
  input wire logic drive_creep,
  input wire logic dir_fwd,
  input wire logic dir_bwd,
  input wire logic in_position
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_one_stage: assert property ($onehot0({drive_fast, drive_slow, drive_creep}))
    else $error("more than one speed stage");
  a_dir_single: assert property (!(dir_fwd && dir_bwd))
    else $error("both directions driven");
  a_stage_has_dir: assert property ((drive_fast || drive_slow || drive_creep) |-> (dir_fwd || dir_bwd))
    else $error("speed stage without direction");
  a_stop_quiet: assert property (in_position |-> !(drive_fast || drive_slow || drive_creep || dir_fwd || dir_bwd))
    else $error("drive active at stop point");
  a_creep_last: assert property ($fell(drive_creep) |-> !drive_fast && !drive_slow)
    else $error("faster stage after creep");
  a_stop_edge: assert property ($rose(in_position) |-> $past(drive_fast || drive_slow || drive_creep))
    else $error("stop point without preceding motion");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  c_slow: cover property ($rose(drive_slow));
  c_back: cover property ($rose(dir_bwd));
  c_stop: cover property ($rose(in_position));
endmodule
bind axis_position axis_monitor axis_monitor_i (.*);

// ===== verification/enc_model.sv
`timescale 1ns/100ps
module enc_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // drive outputs of the axis
  input wire logic drive_fast,
  input wire logic drive_slow,
  input wire logic dir_fwd,
  input wire logic dir_bwd,
  // encoder tracks
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph_q;
  logic [4:0] wait_q;
  int cnt;
  // gray phase: only one track moves per step
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
  // slower stages step less often, tracks freeze without a direction
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_q <= 2'h0;
      wait_q <= 5'h00;
      cnt <= 0;
    end else if (!(dir_fwd || dir_bwd)) begin
      wait_q <= 5'h00;
    end else if (wait_q != 5'h00) begin
      wait_q <= wait_q - 5'h01;
    end else begin
      wait_q <= drive_fast ? 5'h07 : (drive_slow ? 5'h0F : 5'h17);
      ph_q <= dir_fwd ? ph_q + 2'h1 : ph_q - 2'h1;
      cnt <= dir_fwd ? cnt + 1 : cnt - 1;
    end
  end
endmodule

// ===== verification/axis_position_tb.sv
`timescale 1ns/100ps
`include "axis_defines.svh"
module axis_position_tb;
  localparam int F = 2;
  logic mclk = 0, rst = 1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic enc_a, enc_b, retract_in = 0, escape_key = 0, slow_prev = 0, creep_prev = 0;
  logic drive_fast, drive_slow, drive_creep, dir_fwd, dir_bwd, tol_zone, in_position;
  int bad_count = 0, total_checks = 0, cycles = 0, base = 0, goal = 0, sl_rem = 0, cr_rem = 0;
  axis_position #(.ESC_HOLD_CYC(50), .TICK_CYC(4)) axis_position_i (.*);
  enc_model enc_model_i (.*);
  initial forever #4 mclk = ~mclk;
  function automatic int rem();
    int p;
    p = base + enc_model_i.cnt * F;
    return dir_fwd ? goal - p : p - goal;
  endfunction
  // ----------------------------------------
  // watchdog and stage switch points
  // ----------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
    if (drive_slow && !slow_prev) sl_rem = rem();
    if (drive_creep && !creep_prev) cr_rem = rem();
    slow_prev = drive_slow;
    creep_prev = drive_creep;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic par(input logic [3:0] i, input logic [31:0] d);
    wr(8'h40 + {2'b00, i, 2'b00}, d);
  endtask
  // move, then judge stage switch points and the stop point
  task automatic mv(input int t, input int g, input int e, input int s, input int c);
    goal = g;
    sl_rem = -99;
    cr_rem = -99;
    wr(`OFS_TARGET, t);
    wr(`OFS_CMD, 32'h1);
    fin(e, s, c);
    $display("move to %0d done", t);
  endtask
  task automatic fin(input int e, input int s, input int c);
    repeat (2) @(posedge mclk);
    while (!in_position) @(posedge mclk);
    rd(`OFS_ACTUAL);
    chk(v, e);
    chk(sl_rem <= s && sl_rem >= s - F, 1);
    chk(cr_rem <= c && cr_rem >= c - F, 1);
    chk({drive_fast, drive_slow, drive_creep, dir_fwd, dir_bwd}, 0);
  endtask
  task automatic t_lock();
    wr(`OFS_PIN, `PIN_CODE);
    rd(`OFS_STATUS);
    chk(v[12], 0);
    escape_key <= 1;
    repeat (20) @(posedge mclk);
    escape_key <= 0;
    rd(`OFS_STATUS);
    chk(v[13], 0);
    escape_key <= 1; // held past the scaled hold time
    repeat (60) @(posedge mclk);
    escape_key <= 0;
    rd(`OFS_STATUS);
    chk(v[13], 1);
    wr(`OFS_PIN, `PIN_CODE);
    rd(`OFS_STATUS);
    chk(v[12], 1);
    rd(8'h2C);
    chk(v, 32'h0);
    chk(resp, `RESP_SLVERR);
    wr(8'h30, 32'h1);
    chk(resp, `RESP_SLVERR);
    $display("lock test done");
  endtask
  task automatic t_zone();
    par(`PI_TOL, 32'd10);
    par(`PI_MANIP, 32'd8);
    @(posedge mclk);
    chk(tol_zone, 1);
    wr(`OFS_CTRL, 32'h11);
    @(posedge mclk);
    chk(tol_zone, 0);
    wr(`OFS_CTRL, 32'h1);
    par(`PI_TOL, 32'd4);
    @(posedge mclk);
    chk(tol_zone, 0);
    rd(`OFS_DISPLAY);
    chk(v, 32'd50);
    rd(`OFS_ACTUAL);
    chk(v, 32'd56);
    $display("zone test done");
  endtask
  task automatic t_ref();
    par(`PI_REF, 32'd1000);
    wr(`OFS_CMD, 32'h4);
    base = 1000 - enc_model_i.cnt * F;
    rd(`OFS_ACTUAL);
    chk(v, 32'd1000);
    par(`PI_END_MAX, 32'd1100);
    mv(2000, 1100, 1096, 100, 40);
  endtask
  task automatic t_retract();
    par(`PI_RETR, 32'h3E8);
    wr(`OFS_CTRL, 32'h21);
    goal = 1000;
    sl_rem = -99;
    cr_rem = -99;
    retract_in <= 1;
    repeat (8) @(posedge mclk);
    retract_in <= 0;
    fin(1006, 60, 20);
    $display("retract test done");
  endtask
  // overrun, dwell with drives off, then return
  task automatic lp(input int t, input int e);
    wr(`OFS_TARGET, t);
    wr(`OFS_CMD, 32'h1);
    do rd(`OFS_STATUS); while (!v[3]);
    chk(v[9:5], 0);
    while (!in_position) @(posedge mclk);
    rd(`OFS_ACTUAL);
    chk(v, e);
  endtask
  task automatic t_loop();
    par(`PI_COMP, 32'h28);
    par(`PI_DWELL, 32'h5);
    wr(`OFS_CTRL, 32'h41);
    lp(900, 896);
    par(`PI_COMP, 32'h0);
    par(`PI_LOOP, 32'h14);
    lp(900, 896);
    par(`PI_LOOP, 32'h0);
    $display("loop test done");
  endtask
  task automatic t_prog();
    wr(`OFS_PROG_ADDR, 32'h0);
    wr(`OFS_PROG_DATA, 32'h2BC);
    wr(`OFS_PROG_DATA, 32'h320);
    wr(`OFS_PROG_LEN, 32'h2);
    wr(`OFS_CTRL, 32'h2);
    goal = 800;
    wr(`OFS_CMD, 32'h1);
    fin(796, 94, 40);
    rd(`OFS_SET_IDX);
    chk(v, 32'h1);
    $display("program test done");
  endtask
  task automatic t_jog();
    wr(`OFS_CTRL, 32'h4);
    repeat (3) @(posedge mclk);
    chk({drive_fast, drive_slow, drive_creep, dir_fwd, dir_bwd, in_position}, 6'h14);
    wr(`OFS_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    chk({drive_fast, drive_slow, drive_creep, dir_fwd, dir_bwd}, 0);
    $display("jog test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    t_lock();
    par(`PI_SLOW_F, 32'd100);
    par(`PI_SLOW_B, 32'd60);
    par(`PI_CREEP_F, 32'd40);
    par(`PI_CREEP_B, 32'd20);
    par(`PI_CORR_F, 32'd4); // kept small
    par(`PI_CORR_B, 32'd6); // kept small
    par(`PI_FACTOR, F);
    wr(`OFS_CTRL, 32'h1);
    mv(200, 200, 196, 100, 40);
    mv(50, 50, 56, 60, 20);
    t_zone();
    t_ref();
    t_retract();
    t_loop();
    t_prog();
    t_jog();
    results();
  end
endmodule
